// >>> bcc_clk_gen.sv
`timescale 1ns/100ps
module bcc_clk_gen
   import bcc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control from the register bank
   bcc_clk_if.gen   cif
);
   logic stop_ff;
   logic clk_ff;
   logic stop_req;
   logic nxt_stop;
   logic nxt_clk;

   // Stop request from the clock-run protocol
   assign stop_req = cif.run_enable &&                                  // see (R3)
                     (cif.run_mode ? (cif.bus_idle && !cif.primary_req) // see (R5)
                                   : cif.d3hot);                        // see (R4)
   // Stop only at a low phase so no runt pulse reaches the slot
   assign nxt_stop = stop_req ? (stop_ff || !clk_ff) : 1'b0;
   assign nxt_clk  = (nxt_stop || cif.slot3_field == BCC_SLOT3_OFF) ? 1'b0 : !clk_ff; // see (R1)

   // Divide-by-two secondary clock and stop flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stop_ff <= 1'b0;
         clk_ff  <= 1'b0;
      end
      else
      begin
         stop_ff <= nxt_stop;
         clk_ff  <= nxt_clk;
      end
   end

   assign cif.stopped = stop_ff;  // see (R2)
   assign cif.clk_out = clk_ff;
endmodule

// >>> bcc_clk_if.sv
`timescale 1ns/100ps
interface bcc_clk_if;
   logic [1:0] slot3_field;
   logic       run_enable;
   logic       run_mode;
   logic       d3hot;
   logic       bus_idle;
   logic       primary_req;
   logic       stopped;
   logic       clk_out;

   modport ctl (output slot3_field, run_enable, run_mode, d3hot, bus_idle, primary_req,
                input stopped, clk_out);
   modport gen (input slot3_field, run_enable, run_mode, d3hot, bus_idle, primary_req,
                output stopped, clk_out);
endinterface

// >>> bcc_pkg.sv
package bcc_pkg;
   // Register byte addresses
   localparam logic [7:0]  BCC_CLKCTL_ADDR   = 8'ha4;
   localparam logic [7:0]  BCC_SUBCAP_ADDR   = 8'ha8;
   localparam logic [7:0]  BCC_CARDID_ADDR   = 8'hac;
   localparam logic [7:0]  BCC_EXPCAP_ADDR   = 8'hb0;

   // Clock control word fields
   localparam int          BCC_SLOT3_LSB     = 6;
   localparam int          BCC_STOP_BIT      = 13;
   localparam int          BCC_RUN_EN_BIT    = 14;
   localparam int          BCC_RUN_MODE_BIT  = 15;
   localparam int          BCC_L0S_BIT       = 16;
   localparam int          BCC_SCRAM_LSB     = 17;
   localparam logic [1:0]  BCC_SLOT3_OFF     = 2'h3;
   localparam logic [1:0]  BCC_SLOT3_RST     = 2'h0;
   localparam logic        BCC_RUN_EN_RST    = 1'h0;
   localparam logic        BCC_RUN_MODE_RST  = 1'h0;
   localparam logic        BCC_L0S_RST       = 1'h1;
   localparam logic [1:0]  BCC_SCRAM_RST     = 2'h0;

   // Capability structure constants
   localparam logic [7:0]  BCC_SUBCAP_ID     = 8'h0d;
   localparam logic [7:0]  BCC_SUBCAP_NEXT   = 8'hb0;
   localparam logic [7:0]  BCC_SUBCAP_NEXT_SI = 8'ha0;
   localparam logic [7:0]  BCC_EXPCAP_ID     = 8'h10;
   localparam logic [7:0]  BCC_EXPCAP_NEXT   = 8'hf0;
   localparam logic [3:0]  BCC_EXPCAP_VER    = 4'h1;
   localparam logic [3:0]  BCC_PORT_TYPE     = 4'h7;
   localparam logic        BCC_SLOT_IMPL     = 1'h0;
   localparam logic [4:0]  BCC_MSG_NUM       = 5'h00;
   localparam logic [15:0] BCC_CARD_VENDOR   = 16'h0000;  // Arbitrary value
   localparam logic [15:0] BCC_CARD_ID       = 16'h0000;  // Arbitrary value
endpackage

// >>> bcc_props.sv
`timescale 1ns/100ps
module bcc_props (
   // Bus side
   input wire logic        pclk, presetn, pwrite, pready,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata, prdata,
   // Bridge side
   input wire logic        d3hot, sec_bus_idle, primary_req, rx_elec_idle, slot_id_cap_en,
   input wire logic        slot3_bus_clock_out, l0s_entry_allowed
);
   logic [31:0] sh_ff;
   logic [1:0]  up_ff;
   wire         rd  = pready & ~pwrite;
   wire         off = sh_ff[7:6] == 2'h3;
   wire         stp = sh_ff[14] & (sh_ff[15] ? sec_bus_idle & ~primary_req : d3hot);
   wire         ok  = up_ff == 2'h3;

   // Shadow of writable bits; up_ff hides the first edges after reset
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         sh_ff <= 32'h10000;
         up_ff <= 2'h0;
      end
      else
      begin
         up_ff <= up_ff + {1'h0, !ok};
         if (pready & pwrite & (paddr == 8'ha4))
            sh_ff <= pwdata & 32'h7c0c0;
      end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_sub;
      rd && paddr == 8'ha8 |-> prdata == {16'h0, ($past(slot_id_cap_en) ? 8'ha0 : 8'hb0), 8'h0d};
   endproperty
   a_sub: assert property (p_sub) else $error("subsystem header");
   property p_card; rd && paddr == 8'hac |-> prdata == 32'h0; endproperty
   a_card: assert property (p_card) else $error("card ident");
   property p_exp; rd && paddr == 8'hb0 |-> prdata == 32'h0071f010; endproperty
   a_exp: assert property (p_exp) else $error("express header");
   property p_ctl; rd && paddr == 8'ha4 |-> (prdata & 32'hffffdfff) == sh_ff; endproperty
   a_ctl: assert property (p_ctl) else $error("control word");
   property p_l0s; ok |-> l0s_entry_allowed == $past(~sh_ff[16] | rx_elec_idle); endproperty
   a_l0s: assert property (p_l0s) else $error("l0s permit");
   property p_off; off && $past(off) |-> !slot3_bus_clock_out; endproperty
   a_off: assert property (p_off) else $error("slot clock not off");
   property p_run; (ok && !stp && !off)[*3] |-> $changed(slot3_bus_clock_out); endproperty
   a_run: assert property (p_run) else $error("slot clock idle");
   property p_stop; stp[*4] |-> !slot3_bus_clock_out; endproperty
   a_stop: assert property (p_stop) else $error("slot clock not stopped");
   c_stop: cover property (stp[*4]);
   c_slot: cover property (rd && paddr == 8'ha8 && slot_id_cap_en);
   c_off: cover property (off[*4]);
endmodule

// >>> bcc_regs.sv
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
// Summary of operation
// (R1) Slot 3 clock toggles for enable codes 00, 01 and 10 and is held low for 11.
// (R2) Status bit 13 reads 1 while the secondary clock is stopped, else 0, reset 0.
// (R3) Bit 14 enables clock-run stopping, reset 0; no stopping while it is 0.
// (R4) With mode bit 15 at 0 (reset) the clock stops only in D3hot.
// (R5) With mode bit 15 at 1 the clock stops when the bus is idle and nothing is pending.
// (R6) Bit 16 resets to 1; at 1 L0s needs receiver idle, at 0 L0s is always allowed.
// (R7) The header at A8h reads 0Dh in its low byte.
// (R8) The A8h next pointer reads B0h, or A0h when slot identification is enabled.
// (R9) Bits 15:0 at ACh give the read-only subsystem vendor identifier.
// (R10) Bits 31:16 at ACh give the read-only subsystem identifier.
// (R11) The low byte at B0h reads 10h.
// (R12) Bits 15:8 at B0h read F0h.
// (R13) Bits 23:20 at B0h read 7h, a bridge from the express link to the parallel bus.
// (R14) Reserved bits read zero and ignore writes.
module bcc_regs
   import bcc_pkg::*;
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Bridge status
   input  wire logic        d3hot,
   input  wire logic        sec_bus_idle,
   input  wire logic        primary_req,
   input  wire logic        rx_elec_idle,
   input  wire logic        slot_id_cap_en,
   // Link and slot controls
   output logic             slot3_bus_clock_out,
   output logic             l0s_entry_allowed,
   output logic [1:0]       scramble_ctrl
);
   logic [1:0]  slot3_ff;
   logic        run_en_ff;
   logic        run_mode_ff;
   logic        l0s_ff;
   logic [1:0]  scram_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [31:0] prdata_ff;
   logic        l0s_ok_ff;
   logic [1:0]  scram_out_ff;

   wire         access;
   wire         hit_clk;
   wire         hit_sub;
   wire         hit_card;
   wire         hit_exp;
   wire         mapped;
   wire         wr_clk;
   wire [31:0]  clk_word;
   wire [31:0]  sub_word;
   wire [31:0]  card_word;
   wire [31:0]  exp_word;
   wire [31:0]  nxt_prdata;
   wire         nxt_l0s_ok;

   bcc_clk_if cif ();

   bcc_clk_gen u_gen
   (
      .pclk    (pclk),
      .presetn (presetn),
      .cif     (cif)
   );

   // Drive the clock generator from the control word and the bridge status inputs
   assign cif.slot3_field = slot3_ff;
   assign cif.run_enable  = run_en_ff;
   assign cif.run_mode    = run_mode_ff;
   assign cif.d3hot       = d3hot;
   assign cif.bus_idle    = sec_bus_idle;
   assign cif.primary_req = primary_req;

   // Address decode; one wait state so read data comes from a flop
   assign access   = psel && penable && !pready_ff;
   assign hit_clk  = paddr == BCC_CLKCTL_ADDR;
   assign hit_sub  = paddr == BCC_SUBCAP_ADDR;
   assign hit_card = paddr == BCC_CARDID_ADDR;
   assign hit_exp  = paddr == BCC_EXPCAP_ADDR;
   assign mapped   = hit_clk || hit_sub || hit_card || hit_exp;
   assign wr_clk   = psel && penable && pready_ff && pwrite && hit_clk;

   // Read words; unlisted bits are constant zero
   assign clk_word = {13'h0000,                        // see (R14)
                      scram_ff,
                      l0s_ff,
                      run_mode_ff,
                      run_en_ff,
                      cif.stopped,                     // see (R2)
                      5'h00,
                      slot3_ff,
                      6'h00};
   assign sub_word = {16'h0000,
                      slot_id_cap_en ? BCC_SUBCAP_NEXT_SI : BCC_SUBCAP_NEXT, // see (R8)
                      BCC_SUBCAP_ID};                  // see (R7)
   assign card_word = {BCC_CARD_ID,                    // see (R10)
                       BCC_CARD_VENDOR};               // see (R9)
   assign exp_word = {2'h0,
                      BCC_MSG_NUM,
                      BCC_SLOT_IMPL,
                      BCC_PORT_TYPE,                   // see (R13)
                      BCC_EXPCAP_VER,
                      BCC_EXPCAP_NEXT,                 // see (R12)
                      BCC_EXPCAP_ID};                  // see (R11)
   assign nxt_prdata = hit_clk  ? clk_word :
                       hit_sub  ? sub_word :
                       hit_card ? card_word :
                       hit_exp  ? exp_word : 32'h0000_0000;

   // L0s policy: receiver idle is needed only when bit 16 is set
   assign nxt_l0s_ok = !l0s_ff || rx_elec_idle;        // see (R6)

   // APB handshake and read data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end
      else
      begin
         pready_ff  <= access;
         pslverr_ff <= access && !mapped;
         if (access && !pwrite)
         begin
            prdata_ff <= nxt_prdata;
         end
      end
   end

   // Writable fields of the clock control word; read-only bits drop writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot3_ff    <= BCC_SLOT3_RST;
         run_en_ff   <= BCC_RUN_EN_RST;                // see (R3)
         run_mode_ff <= BCC_RUN_MODE_RST;              // see (R4)
         l0s_ff      <= BCC_L0S_RST;                   // see (R6)
         scram_ff    <= BCC_SCRAM_RST;
      end
      else if (wr_clk)
      begin
         slot3_ff    <= pwdata[BCC_SLOT3_LSB +: 2];
         run_en_ff   <= pwdata[BCC_RUN_EN_BIT];
         run_mode_ff <= pwdata[BCC_RUN_MODE_BIT];
         l0s_ff      <= pwdata[BCC_L0S_BIT];
         scram_ff    <= pwdata[BCC_SCRAM_LSB +: 2];
      end
   end

   // Registered link controls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         l0s_ok_ff    <= 1'b0;
         scram_out_ff <= BCC_SCRAM_RST;
      end
      else
      begin
         l0s_ok_ff    <= nxt_l0s_ok;
         scram_out_ff <= scram_ff;
      end
   end

   assign prdata              = prdata_ff;
   assign pready              = pready_ff;
   assign pslverr             = pslverr_ff;
   assign slot3_bus_clock_out = cif.clk_out;
   assign l0s_entry_allowed   = l0s_ok_ff;
   assign scramble_ctrl       = scram_out_ff;
endmodule

// >>> test_bridge_clock_and_capability_regs.sv
`timescale 1ns/100ps
module test_bridge_clock_and_capability_regs;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_m, se;
   logic        d3hot, sec_bus_idle, primary_req, rx_elec_idle, slot_id_cap_en;
   logic        slot3_bus_clock_out, l0s_entry_allowed;
   logic [1:0]  scramble_ctrl;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, rnd, ctl_m;
   logic [7:0]  aq[$] = {8'ha4, 8'ha8, 8'hac, 8'hb0, 8'hc0};
   int          err_count, check_count, seed;

   bcc_regs dut (.*);

   initial
   begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // APB transfer; the request stands until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         err_count++;
         summarize;
      end
      rd = prdata;
      se = pslverr;
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask

   // Bench model of every readable word
   function automatic logic [31:0] exp_of(input logic [7:0] a);
      case (a)
         8'ha4: return ctl_m | {18'h0, stop_m, 13'h0};
         8'ha8: return slot_id_cap_en ? 32'ha00d : 32'hb00d;
         8'hb0: return 32'h0071f010;
         default: return 32'h0;
      endcase
   endfunction

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      seed = 76622;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {d3hot, sec_bus_idle, rx_elec_idle, slot_id_cap_en, primary_req} = 5'h18;
      ctl_m = 32'h10000;
      stop_m = 0;
      presetn = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      // Ignored writes, then every word read, without and with slot identification
      repeat (2)
      begin
         foreach (aq[i])
         begin
            xfer(1, aq[i], ($random(seed) & 32'hfff83f3f) | 32'h10000);
            chk("write error", {31'h0, se}, {31'h0, aq[i] == 8'hc0});
            xfer(0, aq[i], 32'h0);
            chk("word", rd, exp_of(aq[i]));
            chk("read error", {31'h0, se}, {31'h0, aq[i] == 8'hc0});
         end
         slot_id_cap_en <= 1;
      end
      $display("map test done");
      // Random control words; D3hot low and a pending request block any stop
      {d3hot, primary_req} <= 2'h1;
      repeat (8)
      begin
         rnd = $random(seed);
         rx_elec_idle <= rnd[0];
         xfer(1, 8'ha4, rnd);
         ctl_m = rnd & 32'h7c0c0;
         xfer(0, 8'ha4, 32'h0);
         chk("control", rd, exp_of(8'ha4));
         chk("l0s", {31'h0, l0s_entry_allowed}, {31'h0, ~ctl_m[16] | rx_elec_idle});
         chk("scramble", {30'h0, scramble_ctrl}, {30'h0, ctl_m[18:17]});
      end
      $display("control test done");
      xfer(1, 8'ha4, 32'hc0);
      repeat (3) @(posedge pclk);
      chk("slot clock", {31'h0, slot3_bus_clock_out}, 32'h0);
      $display("slot off test done");
      // Stop in each mode, each by its own condition only, then release
      for (int i = 0; i < 2; i++)
      begin
         ctl_m = i ? 32'h1c000 : 32'h14000;
         xfer(1, 8'ha4, ctl_m);
         {d3hot, sec_bus_idle, primary_req} <= i ? 3'h2 : 3'h5;
         repeat (6) @(posedge pclk);
         stop_m = 1;
         xfer(0, 8'ha4, 32'h0);
         chk("stopped", rd, exp_of(8'ha4));
         {d3hot, sec_bus_idle, primary_req} <= 3'h1;
         repeat (4) @(posedge pclk);
         stop_m = 0;
         xfer(0, 8'ha4, 32'h0);
         chk("running", rd, exp_of(8'ha4));
      end
      $display("stop test done");
      summarize;
   end

   // Watchdog far beyond the two hundred or so cycles the run needs
   initial
   begin
      #200000;
      err_count++;
      summarize;
   end
endmodule

bind bcc_regs bcc_props u_props (.*);
